//--- src/spi_ctrl_pkg.sv
// Purpose: shared constants for the status and memory write controller
// Assumes: 250 MHz system clock, 9-bit device address space
// Notes:   times kept in their own units, cycle counts derived from them
package spi_ctrl_pkg;
  localparam logic [7:0] LATCH_SET_INSTR       = 8'h06;
  localparam logic [7:0] LATCH_CLEAR_INSTR     = 8'h04;
  localparam logic [7:0] STATUS_WRITE_INSTR    = 8'h01;
  localparam logic [7:0] STATUS_READ_INSTR     = 8'h05;
  localparam logic [7:0] DEFAULTS_RESTORE_INSTR = 8'h07;
  localparam logic [2:0] MEM_WRITE_LOW         = 3'h2;
  localparam logic [2:0] MEM_READ_LOW          = 3'h3;
  localparam int         ADDR_HI_BIT           = 3;
  localparam logic [8:0] USER_LAST             = 9'h0ff;
  localparam logic [8:0] EEREG_LAST            = 9'h10f;
  localparam logic [8:0] ROM_LAST              = 9'h11f;
  localparam logic [8:0] SRAM_FIRST            = 9'h120;
  localparam logic [8:0] SRAM_LAST             = 9'h135;
  localparam logic [8:0] PIO_OUT_LO            = 9'h120;
  localparam logic [8:0] PIO_OUT_HI            = 9'h121;
  localparam logic [8:0] DEFAULTS_BASE         = 9'h10a;
  localparam logic [3:0] EEREG_SKIP            = 4'ha;
  localparam int         SRAM_DEPTH            = 22;
  localparam int         RESTORE_COUNT         = 6;
  localparam int         EE_DEPTH              = 272;
  localparam int         SEG_BYTES             = 16;
  localparam logic [21:0] SRAM_WRITABLE        = 22'h3fffff;
  localparam int         ST_WIP                = 0;
  localparam int         ST_WEN                = 1;
  localparam int         ST_LOCK               = 6;
  localparam int         ST_HWP                = 7;
  localparam logic [5:0] NV_RESET              = 6'h00;
  localparam logic [1:0] BP_BLOCK3             = 2'h1;
  localparam logic [1:0] BP_BLOCK23            = 2'h2;
  localparam logic [1:0] BP_ALL                = 2'h3;
  localparam int         CLK_MHZ               = 250;
  localparam int         PROGRAM_TIME_MS       = 10;
  localparam int         INIT_WAIT_TIME_US     = 1000;
  localparam int         PROGRAM_CYCLES        = PROGRAM_TIME_MS * 1000 * CLK_MHZ;
  localparam int         INIT_WAIT_CYCLES      = INIT_WAIT_TIME_US * CLK_MHZ;
  localparam int         FIFO_WIDTH            = 8;
  localparam int         FIFO_DEPTH            = 8;
  typedef enum logic [1:0] {TGT_USER, TGT_EEREG, TGT_SRAM, TGT_NONE} target_t;
  typedef enum logic [1:0] {PH_INSTR, PH_ADDR, PH_DATA} phase_t;
endpackage : spi_ctrl_pkg

//--- src/spi_status_and_memory_write_ctrl.sv
// Purpose: status and memory write instruction handling of an spi slave
// Assumes: spi mode (0,0) or (1,1); pins sampled by clk_sys
// Notes:   memory write data bytes pass an 8-word fifo before reaching their target
// Summary of operation
// - only status write alters status bits b7:b2
// - status write needs latch and pin protection
// - last complete data byte updates status
// - accepted status write programs, then clears latch
// - refused status write: no cycle, latch kept
// - first read after status write uses upper half
// - status read accepted at any time
// - busy bit refreshed each status byte boundary
// - restore reloads pio registers from defaults
// - start address selects target class
// - user write fills preloaded 16-byte page buffer
// - page pointer wraps from 1111b to 0
// - user program needs unprotected, latch, aligned bits
// - failed user write keeps latch, no program
// - register segment drops first 10 bytes
// - sram bytes act at once, pointer wraps
// - partial byte ignored, lock blocks sram writes
// - pio output start toggles pointer in low current
// - rom or missing space: discard, latch kept
// - sram byte moves at last-bit falling edge, or at deselect in mode (1,1)
// - block protect field decode
// - ninth address bit from instruction bit 3
// - fixed codes for restore and status instructions
// - busy at status b0, latch at b1
`timescale 1ns/1ps

module fifo_buf #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_sys,
  input  wire logic             reset_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_reg;
  logic [AW-1:0]    rd_reg;
  logic [AW:0]      cnt_reg;
  logic             push;
  logic             pop;

  assign in_ready  = cnt_reg != (AW+1)'(DEPTH);
  assign out_valid = cnt_reg != '0;
  assign out_data  = mem_reg[rd_reg];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_reg[wr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wr_reg <= (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;
      end
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : fifo_buf

module spi_status_and_memory_write_ctrl #(
  parameter int PROGRAM_CYCLES   = spi_ctrl_pkg::PROGRAM_CYCLES,
  parameter int INIT_WAIT_CYCLES = spi_ctrl_pkg::INIT_WAIT_CYCLES
) (
  input  wire logic       clk_sys,
  input  wire logic       reset_n,
  input  wire logic       sck,
  input  wire logic       chip_select_n,
  input  wire logic       mosi,
  input  wire logic       protect_pin_n,
  input  wire logic       high_current_sel,
  output logic            miso,
  output logic            miso_oe,
  output logic            write_in_progress,
  output logic            restore_busy,
  output logic      [7:0] status_byte,
  output logic      [7:0] pio_out_lo,
  output logic      [7:0] pio_out_hi
);
  logic cs_s1, cs_s2, cs_d, sck_s1, sck_s2, sck_d, mosi_s1, mosi_s2, pin_s1, pin_s2;
  logic [2:0]  bit_cnt_reg;
  logic [7:0]  shift_reg;
  logic [7:0]  cmd_reg;
  logic        cmd_ok_reg;
  logic        seen_rise_reg;
  logic [7:0]  hold_reg;
  logic        pending_reg;
  logic [7:0]  status_write_instr_data_reg;
  logic        status_write_instr_have_reg;
  logic        data_seen_reg;
  logic        end_pending_reg;
  logic        aligned_reg;
  logic        force_high_reg;
  logic        toggle_reg;
  logic [8:0]  ptr_reg;
  logic [8:0]  rd_ptr_reg;
  logic        rd_first_reg;
  logic [7:0]  tx_reg;
  logic        oe_reg;
  logic [5:0]  nv_reg;
  logic        wen_reg;
  logic        prog_busy_reg;
  logic        rest_busy_reg;
  logic [23:0] prog_cnt_reg;
  logic [23:0] rest_cnt_reg;
  logic        wen_drop_reg;
  logic        any_wr_reg;
  logic        sram_wrote_reg;
  logic [7:0]  page_reg [spi_ctrl_pkg::SEG_BYTES];
  logic [7:0]  ee_reg   [spi_ctrl_pkg::EE_DEPTH];
  logic [7:0]  sram_reg [spi_ctrl_pkg::SRAM_DEPTH];
  spi_ctrl_pkg::phase_t  phase_reg;
  spi_ctrl_pkg::target_t tgt_reg;

  logic        cs_fall, cs_rise, active, sck_rise, sck_fall, byte_done;
  logic [7:0]  rx_byte;
  logic        busy, is_write, is_read, preload, push, pop, end_go;
  logic        fifo_in_ready, fifo_out_valid;
  logic [7:0]  fifo_out_data;
  logic        prog_start, commit, restore_start, status_write_instr_ok, user_prot;
  logic [8:0]  addr_full;
  logic [4:0]  sram_idx;
  logic [7:0]  rd_data;
  logic [7:0]  status_now;

  // pins pass two flops before use
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      {cs_s1, cs_s2, cs_d} <= 3'h7;
      {sck_s1, sck_s2, sck_d} <= 3'h0;
      {mosi_s1, mosi_s2, pin_s1, pin_s2} <= 4'h0;
    end else begin
      {cs_s1, cs_s2, cs_d} <= {chip_select_n, cs_s1, cs_s2};
      {sck_s1, sck_s2, sck_d} <= {sck, sck_s1, sck_s2};
      {mosi_s1, mosi_s2, pin_s1, pin_s2} <= {mosi, mosi_s1, protect_pin_n, pin_s1};
    end
  end

  assign cs_fall   = cs_d & ~cs_s2;
  assign cs_rise   = ~cs_d & cs_s2;
  assign active    = ~cs_s2 & ~cs_d;
  assign sck_rise  = active & sck_s2 & ~sck_d;
  assign sck_fall  = active & ~sck_s2 & sck_d & seen_rise_reg;
  assign byte_done = sck_rise & (bit_cnt_reg == 3'h7);
  assign rx_byte   = {shift_reg[6:0], mosi_s2};
  assign busy      = prog_busy_reg | rest_busy_reg;
  assign is_write  = cmd_ok_reg & (cmd_reg[7:4] == 4'h0) & (cmd_reg[2:0] == spi_ctrl_pkg::MEM_WRITE_LOW);
  assign is_read   = cmd_ok_reg & (cmd_reg[7:4] == 4'h0) & (cmd_reg[2:0] == spi_ctrl_pkg::MEM_READ_LOW);
  assign addr_full = {(force_high_reg & is_read) | cmd_reg[spi_ctrl_pkg::ADDR_HI_BIT],
                      rx_byte};
  assign preload   = byte_done & (phase_reg == spi_ctrl_pkg::PH_ADDR) & is_write;
  assign restore_start = byte_done & (phase_reg == spi_ctrl_pkg::PH_INSTR) & ~busy
                       & (rx_byte == spi_ctrl_pkg::DEFAULTS_RESTORE_INSTR);
  assign status_now = {nv_reg, wen_reg, prog_busy_reg};

  // frame decode: instruction, address, data bytes
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      bit_cnt_reg   <= 3'h0;
      shift_reg     <= 8'h00;
      cmd_reg       <= 8'h00;
      cmd_ok_reg    <= 1'b0;
      seen_rise_reg <= 1'b0;
      phase_reg     <= spi_ctrl_pkg::PH_INSTR;
      hold_reg      <= 8'h00;
      pending_reg   <= 1'b0;
      status_write_instr_data_reg <= 8'h00;
      status_write_instr_have_reg <= 1'b0;
      data_seen_reg <= 1'b0;
      tgt_reg       <= spi_ctrl_pkg::TGT_NONE;
    end else if (cs_fall) begin
      bit_cnt_reg   <= 3'h0;
      seen_rise_reg <= 1'b0;
      phase_reg     <= spi_ctrl_pkg::PH_INSTR;
      pending_reg   <= 1'b0;
      status_write_instr_have_reg <= 1'b0;
      data_seen_reg <= 1'b0;
      cmd_ok_reg    <= 1'b0;
    end else begin
      if (sck_rise) begin
        shift_reg     <= rx_byte;
        bit_cnt_reg   <= bit_cnt_reg + 3'h1;
        seen_rise_reg <= 1'b1;
      end
      if (push) begin
        pending_reg <= 1'b0;
      end
      if (byte_done) begin
        case (phase_reg)
          spi_ctrl_pkg::PH_INSTR: begin
            cmd_reg    <= rx_byte;
            cmd_ok_reg <= ~busy | (rx_byte == spi_ctrl_pkg::STATUS_READ_INSTR);
            phase_reg  <= spi_ctrl_pkg::PH_ADDR;
          end
          spi_ctrl_pkg::PH_ADDR: begin
            phase_reg <= spi_ctrl_pkg::PH_DATA;
            status_write_instr_data_reg <= rx_byte;
            status_write_instr_have_reg <= 1'b1;
            if (addr_full <= spi_ctrl_pkg::USER_LAST) begin
              tgt_reg <= spi_ctrl_pkg::TGT_USER;
            end else if (addr_full <= spi_ctrl_pkg::EEREG_LAST) begin
              tgt_reg <= spi_ctrl_pkg::TGT_EEREG;
            end else if (addr_full <= spi_ctrl_pkg::ROM_LAST) begin
              tgt_reg <= spi_ctrl_pkg::TGT_NONE;
            end else if (addr_full <= spi_ctrl_pkg::SRAM_LAST) begin
              tgt_reg <= spi_ctrl_pkg::TGT_SRAM;
            end else begin
              tgt_reg <= spi_ctrl_pkg::TGT_NONE;
            end
          end
          spi_ctrl_pkg::PH_DATA: begin
            hold_reg      <= rx_byte;
            pending_reg   <= is_write;
            data_seen_reg <= 1'b1;
            status_write_instr_data_reg <= rx_byte;
          end
          default: phase_reg <= spi_ctrl_pkg::PH_INSTR;
        endcase
      end
    end
  end

  // data byte moves on the last-bit falling edge, or at deselect in mode (1,1)
  assign push = pending_reg & fifo_in_ready & (sck_fall | cs_rise);
  assign pop  = fifo_out_valid & ~preload;

  fifo_buf #(
    .WIDTH (spi_ctrl_pkg::FIFO_WIDTH),
    .DEPTH (spi_ctrl_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .reset_n   (reset_n),
    .in_valid  (pending_reg & (sck_fall | cs_rise)),
    .in_ready  (fifo_in_ready),
    .in_data   (hold_reg),
    .out_valid (fifo_out_valid),
    .out_ready (~preload),
    .out_data  (fifo_out_data)
  );

  // end of frame is judged once every received byte has drained
  assign end_go  = end_pending_reg & ~fifo_out_valid;
  assign status_write_instr_ok = cmd_ok_reg & (cmd_reg == spi_ctrl_pkg::STATUS_WRITE_INSTR) & status_write_instr_have_reg
                 & wen_reg & (~nv_reg[spi_ctrl_pkg::ST_HWP - 2] | pin_s2);
  always_comb begin
    case (nv_reg[1:0])
      spi_ctrl_pkg::BP_BLOCK3:  user_prot = ptr_reg[7:6] == 2'h3;
      spi_ctrl_pkg::BP_BLOCK23: user_prot = ptr_reg[7];
      spi_ctrl_pkg::BP_ALL:     user_prot = 1'b1;
      default:                  user_prot = 1'b0;
    endcase
  end
  assign commit = end_go & is_write & wen_reg & aligned_reg & data_seen_reg
                & (((tgt_reg == spi_ctrl_pkg::TGT_USER) & ~user_prot)
                 | ((tgt_reg == spi_ctrl_pkg::TGT_EEREG) & any_wr_reg));
  assign prog_start = commit | (end_go & status_write_instr_ok);

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      end_pending_reg <= 1'b0;
      aligned_reg     <= 1'b0;
    end else if (cs_rise) begin
      end_pending_reg <= 1'b1;
      aligned_reg     <= bit_cnt_reg == 3'h0;
    end else if (end_go) begin
      end_pending_reg <= 1'b0;
    end
  end

  // status register: nonvolatile bits and write latch
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      nv_reg         <= spi_ctrl_pkg::NV_RESET;
      wen_reg        <= 1'b0;
      wen_drop_reg   <= 1'b0;
      force_high_reg <= 1'b0;
    end else begin
      if (end_go & cmd_ok_reg & (cmd_reg == spi_ctrl_pkg::LATCH_SET_INSTR)) begin
        wen_reg <= 1'b1;
      end
      if (end_go & cmd_ok_reg & (cmd_reg == spi_ctrl_pkg::LATCH_CLEAR_INSTR)) begin
        wen_reg <= 1'b0;
      end
      if (end_go & is_write & (tgt_reg == spi_ctrl_pkg::TGT_SRAM) & sram_wrote_reg) begin
        wen_reg <= 1'b0;
      end
      if (end_go & cmd_ok_reg & (cmd_reg == spi_ctrl_pkg::STATUS_WRITE_INSTR)) begin
        force_high_reg <= 1'b1;
      end else if (preload | (byte_done & (phase_reg == spi_ctrl_pkg::PH_ADDR) & is_read)) begin
        force_high_reg <= 1'b0;
      end
      if (end_go & status_write_instr_ok) begin
        nv_reg <= status_write_instr_data_reg[7:2];
      end
      if (prog_start) begin
        wen_drop_reg <= 1'b1;
      end else if (prog_busy_reg & (prog_cnt_reg == 24'h0)) begin
        wen_drop_reg <= 1'b0;
        wen_reg      <= ~wen_drop_reg & wen_reg;
      end
    end
  end

  // programming and restore timers
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      prog_busy_reg <= 1'b0;
      prog_cnt_reg  <= 24'h0;
      rest_busy_reg <= 1'b0;
      rest_cnt_reg  <= 24'h0;
    end else begin
      if (prog_start) begin
        prog_busy_reg <= 1'b1;
        prog_cnt_reg  <= 24'(PROGRAM_CYCLES - 1);
      end else if (prog_busy_reg) begin
        prog_busy_reg <= prog_cnt_reg != 24'h0;
        prog_cnt_reg  <= prog_cnt_reg - 24'h1;
      end
      if (restore_start) begin
        rest_busy_reg <= 1'b1;
        rest_cnt_reg  <= 24'(INIT_WAIT_CYCLES - 1);
      end else if (rest_busy_reg) begin
        rest_busy_reg <= rest_cnt_reg != 24'h0;
        rest_cnt_reg  <= rest_cnt_reg - 24'h1;
      end
    end
  end

  // write pointer and page buffer
  assign sram_idx = 5'(ptr_reg - spi_ctrl_pkg::SRAM_FIRST);
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ptr_reg    <= 9'h000;
      toggle_reg <= 1'b0;
      any_wr_reg <= 1'b0;
    end else if (preload) begin
      ptr_reg    <= addr_full;
      toggle_reg <= ~high_current_sel & ((addr_full == spi_ctrl_pkg::PIO_OUT_LO)
                  | (addr_full == spi_ctrl_pkg::PIO_OUT_HI));
      any_wr_reg <= 1'b0;
    end else if (pop) begin
      case (tgt_reg)
        spi_ctrl_pkg::TGT_USER, spi_ctrl_pkg::TGT_EEREG: begin
          ptr_reg <= {ptr_reg[8:4], ptr_reg[3:0] + 4'h1};
          if (tgt_reg == spi_ctrl_pkg::TGT_USER || ptr_reg[3:0] >= spi_ctrl_pkg::EEREG_SKIP) begin
            any_wr_reg <= 1'b1;
          end
        end
        spi_ctrl_pkg::TGT_SRAM: begin
          if (toggle_reg) begin
            ptr_reg <= {ptr_reg[8:1], ~ptr_reg[0]};
          end else if (ptr_reg == spi_ctrl_pkg::SRAM_LAST) begin
            ptr_reg <= spi_ctrl_pkg::SRAM_FIRST;
          end else begin
            ptr_reg <= ptr_reg + 9'h001;
          end
        end
        default: ptr_reg <= ptr_reg;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    for (int i = 0; i < spi_ctrl_pkg::SEG_BYTES; i++) begin
      if (preload && addr_full <= spi_ctrl_pkg::EEREG_LAST) begin
        page_reg[i] <= ee_reg[{addr_full[8:4], 4'(i)}];
      end else if (pop && ptr_reg[3:0] == 4'(i) && (tgt_reg == spi_ctrl_pkg::TGT_USER
               || (tgt_reg == spi_ctrl_pkg::TGT_EEREG && 4'(i) >= spi_ctrl_pkg::EEREG_SKIP))) begin
        page_reg[i] <= fifo_out_data;
      end
    end
  end

  // nonvolatile store: whole segment written at program start
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      for (int j = 0; j < spi_ctrl_pkg::EE_DEPTH; j++) begin
        ee_reg[j] <= 8'h00;
      end
    end else if (commit) begin
      for (int i = 0; i < spi_ctrl_pkg::SEG_BYTES; i++) begin
        ee_reg[{ptr_reg[8:4], 4'(i)}] <= page_reg[i];
      end
    end
  end

  // sram, pio and nv sram space
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      for (int j = 0; j < spi_ctrl_pkg::SRAM_DEPTH; j++) begin
        sram_reg[j] <= 8'h00;
      end
      sram_wrote_reg <= 1'b0;
    end else begin
      if (preload) begin
        sram_wrote_reg <= 1'b0;
      end
      if (restore_start) begin
        for (int i = 0; i < spi_ctrl_pkg::RESTORE_COUNT; i++) begin
          sram_reg[i] <= ee_reg[spi_ctrl_pkg::DEFAULTS_BASE + 9'(i)];
        end
      end else if (pop && tgt_reg == spi_ctrl_pkg::TGT_SRAM && wen_reg
                   && !nv_reg[spi_ctrl_pkg::ST_LOCK - 2] && SRAM_OK(sram_idx)) begin
        sram_reg[sram_idx] <= fifo_out_data;
        sram_wrote_reg     <= 1'b1;
      end
    end
  end

  function automatic logic SRAM_OK(input logic [4:0] idx);
    SRAM_OK = spi_ctrl_pkg::SRAM_WRITABLE[idx];
  endfunction : SRAM_OK

  // read side: status byte reloads at each byte boundary
  always_comb begin
    if (rd_ptr_reg <= spi_ctrl_pkg::EEREG_LAST) begin
      rd_data = ee_reg[rd_ptr_reg];
    end else if (rd_ptr_reg >= spi_ctrl_pkg::SRAM_FIRST && rd_ptr_reg <= spi_ctrl_pkg::SRAM_LAST) begin
      rd_data = sram_reg[5'(rd_ptr_reg - spi_ctrl_pkg::SRAM_FIRST)];
    end else begin
      rd_data = 8'h00;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      tx_reg       <= 8'h00;
      oe_reg       <= 1'b0;
      rd_ptr_reg   <= 9'h000;
      rd_first_reg <= 1'b0;
    end else if (~active) begin
      oe_reg <= 1'b0;
    end else begin
      if (byte_done && phase_reg == spi_ctrl_pkg::PH_ADDR && is_read) begin
        rd_ptr_reg   <= addr_full;
        rd_first_reg <= 1'b1;
      end
      if (sck_fall && bit_cnt_reg == 3'h0) begin
        if (cmd_ok_reg && cmd_reg == spi_ctrl_pkg::STATUS_READ_INSTR
            && phase_reg != spi_ctrl_pkg::PH_INSTR) begin
          tx_reg <= status_now;
          oe_reg <= 1'b1;
        end else if (is_read && phase_reg == spi_ctrl_pkg::PH_DATA) begin
          oe_reg       <= 1'b1;
          rd_first_reg <= 1'b0;
          tx_reg       <= rd_first_reg ? status_now : rd_data;
          if (!rd_first_reg) begin
            rd_ptr_reg <= (rd_ptr_reg == spi_ctrl_pkg::SRAM_LAST) ? 9'h000 : rd_ptr_reg + 9'h001;
          end
        end
      end else if (sck_fall) begin
        tx_reg <= {tx_reg[6:0], 1'b0};
      end
    end
  end

  assign miso              = tx_reg[7];
  assign miso_oe           = oe_reg;
  assign write_in_progress = prog_busy_reg;
  assign restore_busy      = rest_busy_reg;
  assign status_byte       = {nv_reg, wen_reg, prog_busy_reg};
  assign pio_out_lo        = sram_reg[0];
  assign pio_out_hi        = sram_reg[1];
endmodule : spi_status_and_memory_write_ctrl

//--- dv/spi_ctrl_asserts.sv
// Purpose: port checks of the status and memory write controller
// Assumes: one clock domain, reset_n asynchronous active low
// Notes:   counters measure busy lengths
`timescale 1ns/1ps
module ctrl_asserts #(
  parameter int PROGRAM_CYCLES   = 20,
  parameter int INIT_WAIT_CYCLES = 10
) (
  input wire logic       clk_sys,
  input wire logic       reset_n,
  input wire logic       chip_select_n,
  input wire logic       write_in_progress,
  input wire logic       restore_busy,
  input wire logic [7:0] status_byte
);
  logic [31:0] wip_cnt_reg;
  logic [31:0] rst_cnt_reg;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) wip_cnt_reg <= '0;
    else wip_cnt_reg <= write_in_progress ? wip_cnt_reg + 1 : '0;
  end
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) rst_cnt_reg <= '0;
    else rst_cnt_reg <= restore_busy ? rst_cnt_reg + 1 : '0;
  end
  prog_len_a: assert property ($fell(write_in_progress) |-> wip_cnt_reg == PROGRAM_CYCLES)
    else $error("program time length wrong");
  restore_len_a: assert property ($fell(restore_busy) |-> rst_cnt_reg == INIT_WAIT_CYCLES)
    else $error("restore wait length wrong");
  prog_start_a: assert property ($rose(write_in_progress) |-> chip_select_n)
    else $error("programming began inside a frame");
  restore_start_a: assert property ($rose(restore_busy) |-> !chip_select_n)
    else $error("restore did not begin at the instruction");
  latch_clear_a: assert property ($fell(write_in_progress) |-> ##[0:2] !status_byte[1])
    else $error("latch kept after programming");
  busy_bit_a: assert property (write_in_progress |-> status_byte[0] && status_byte[1])
    else $error("busy or latch bit wrong while programming");
  nv_hold_a: assert property ($changed(status_byte[7:2]) |-> chip_select_n)
    else $error("nv bits changed inside a frame");
  busy_lock_a: assert property ((write_in_progress || restore_busy) |=> !$rose(status_byte[1]))
    else $error("latch set while busy");
  cover property ($rose(write_in_progress));
  cover property ($rose(restore_busy));
  cover property ($fell(status_byte[1]));
endmodule : ctrl_asserts

//--- dv/spi_master_model.sv
// Purpose: spi master in mode (0,0) or (1,1), 8 clk_sys per bit
// Assumes: sck idles at its mode level and stands still between frames
// Notes:   mosi shows the inverse of its last bit once released
`timescale 1ns/1ps
module spi_master_model (
  input wire logic clk_sys,
  input wire logic miso,
  output logic     sck,
  output logic     chip_select_n,
  output logic     mosi
);
  logic mode11 = 1'b0;
  initial begin
    sck = 1'b0;
    chip_select_n = 1'b1;
    mosi = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : tick
  task automatic bit1(input logic v, output logic s);
    mosi <= v;
    if (mode11) sck <= 1'b0;
    tick(4);
    s = miso;
    sck <= 1'b1;
    tick(4);
    if (!mode11) sck <= 1'b0;
  endtask : bit1
  task automatic set_mode(input logic m);
    mode11 = m;
    sck <= m;
    tick(4);
  endtask : set_mode
  task automatic xfer(input logic [7:0] b, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) bit1(b[i], r[i]);
  endtask : xfer
  task automatic start;
    chip_select_n <= 1'b0;
    tick(4);
  endtask : start
  task automatic stop;
    tick(4);
    chip_select_n <= 1'b1;
    mosi <= ~mosi;
    tick(16);
  endtask : stop
endmodule : spi_master_model

//--- dv/spi_status_and_memory_write_ctrl_bench.sv
// Purpose: self-checking bench of the status and memory write controller
// Assumes: shortened program and restore times
// Notes:   one task per scenario
`timescale 1ns/1ps
module spi_status_and_memory_write_ctrl_bench;
  localparam int PROGRAM_CYCLES   = 400;
  localparam int INIT_WAIT_CYCLES = 200;
  logic       clk_sys, reset_n, protect_pin_n, high_current_sel, sck, chip_select_n, mosi;
  logic       miso, miso_oe, write_in_progress, restore_busy;
  logic [7:0] status_byte, pio_out_lo, pio_out_hi;
  int         failures, n_tests, cycles;
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  spi_status_and_memory_write_ctrl #(.PROGRAM_CYCLES(PROGRAM_CYCLES),
    .INIT_WAIT_CYCLES(INIT_WAIT_CYCLES)) dut_u (.clk_sys(clk_sys), .reset_n(reset_n),
    .sck(sck), .chip_select_n(chip_select_n), .mosi(mosi), .protect_pin_n(protect_pin_n),
    .high_current_sel(high_current_sel), .miso(miso), .miso_oe(miso_oe),
    .write_in_progress(write_in_progress), .restore_busy(restore_busy),
    .status_byte(status_byte), .pio_out_lo(pio_out_lo), .pio_out_hi(pio_out_hi));
  spi_master_model m_u (.clk_sys(clk_sys), .miso(miso), .sck(sck),
    .chip_select_n(chip_select_n), .mosi(mosi));
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", what, exp, got);
      failures++;
    end
  endtask : chk
  task automatic report_and_stop;
    if (failures == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : report_and_stop
  task automatic frame(input int n, input logic [39:0] w);
    logic [7:0] r;
    m_u.start();
    for (int i = 0; i < n; i++) m_u.xfer(n == 1 ? w[7:0] : w[39-8*i -: 8], r);
    m_u.stop();
  endtask : frame
  task automatic idle;
    while ((write_in_progress | restore_busy) !== 1'b0)
      @(posedge clk_sys);
    repeat (4) @(posedge clk_sys);
  endtask : idle
  task automatic s_sram;
    frame(1, 40'h06);
    frame(5, 40'h0a20a53c77);
    chk("lo", 8'h77, pio_out_lo);
    chk("hi", 8'h3c, pio_out_hi);
    chk("status", 8'h00, status_byte);
    frame(3, 40'h0a20110000);
    chk("lo", 8'h77, pio_out_lo);
    frame(1, 40'h06);
    frame(3, 40'h0a10550000);
    chk("status", 8'h02, status_byte);
    high_current_sel <= 1'b1;
    m_u.set_mode(1'b1);
    frame(4, 40'h0a20010200);
    m_u.set_mode(1'b0);
    high_current_sel <= 1'b0;
    chk("lo", 8'h01, pio_out_lo);
    chk("hi", 8'h02, pio_out_hi);
  endtask : s_sram
  task automatic s_status;
    logic [7:0] r;
    frame(2, 40'h01fc000000);
    chk("status", 8'h00, status_byte);
    frame(1, 40'h06);
    chk("status", 8'h02, status_byte);
    frame(3, 40'h01fc840000);
    chk("status", 8'h87, status_byte);
    m_u.start();
    m_u.xfer(8'h05, r);
    m_u.xfer(8'h00, r);
    chk("read", 8'h87, r);
    chk("oe", 8'h01, {7'h00, miso_oe});
    for (int i = 0; i < 8 && r[0] !== 1'b0; i++) m_u.xfer(8'h00, r);
    m_u.stop();
    chk("read busy", 8'h00, {7'h00, r[0]});
    idle();
    chk("status", 8'h84, status_byte);
    protect_pin_n <= 1'b0;
    frame(1, 40'h06);
    frame(2, 40'h0100000000);
    chk("status", 8'h86, status_byte);
    protect_pin_n <= 1'b1;
    frame(2, 40'h0100000000);
    idle();
    chk("status", 8'h00, status_byte);
    m_u.start();
    for (int i = 0; i < 4; i++) m_u.xfer(i == 0 ? 8'h03 : (i == 1 ? 8'h20 : 8'h00), r);
    m_u.stop();
    chk("read", 8'h01, r);
  endtask : s_status
  task automatic s_user;
    logic d;
    logic [7:0] r;
    frame(1, 40'h06);
    m_u.start();
    m_u.xfer(8'h02, r);
    m_u.xfer(8'h00, r);
    m_u.xfer(8'h12, r);
    for (int i = 0; i < 3; i++) m_u.bit1(1'b1, d);
    m_u.stop();
    chk("status", 8'h02, status_byte);
    frame(3, 40'h0200120000);
    chk("busy", 8'h01, {7'h00, write_in_progress});
    idle();
    chk("status", 8'h00, status_byte);
    frame(1, 40'h06);
    frame(2, 40'h010c000000);
    idle();
    frame(1, 40'h06);
    frame(3, 40'h0200120000);
    chk("status", 8'h0e, status_byte);
  endtask : s_user
  task automatic s_restore;
    frame(1, 40'h07);
    chk("restore", 8'h01, {7'h00, restore_busy});
    frame(1, 40'h04);
    chk("status", 8'h0e, status_byte);
    idle();
    chk("lo", 8'h00, pio_out_lo);
  endtask : s_restore
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      failures++;
      report_and_stop();
    end
  end
  initial begin
    reset_n = 1'b0;
    protect_pin_n = 1'b1;
    high_current_sel = 1'b0;
    failures = 0;
    n_tests = 0;
    cycles = 0;
    repeat (8) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    chk("status", 8'h00, status_byte);
    s_sram();
    s_status();
    s_user();
    s_restore();
    report_and_stop();
  end
endmodule : spi_status_and_memory_write_ctrl_bench
bind spi_status_and_memory_write_ctrl ctrl_asserts #(.PROGRAM_CYCLES(PROGRAM_CYCLES),
  .INIT_WAIT_CYCLES(INIT_WAIT_CYCLES)) chk_u (.clk_sys(clk_sys), .reset_n(reset_n),
  .chip_select_n(chip_select_n), .write_in_progress(write_in_progress),
  .restore_busy(restore_busy), .status_byte(status_byte));
